// ---- common/outlet_pkg.sv ----
// Constants, types and register map of the outlet linkage relay controller
package outlet_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 4;
	localparam int CAP_W = 28;
	localparam int SUM_W = CAP_W + 4;
	localparam int CLK_PERIOD_NS = 8;
	localparam int NS_PER_MS = 1000000;
	localparam int TICK_MS = 20;
	localparam int TIMEOUT_MS = 200;
	localparam int WDT_MS = 1000;
	localparam int TICKS_TO_TIMEOUT = TIMEOUT_MS / TICK_MS;
	localparam int TICK_CYC_DEF = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int WDT_CYC_DEF = WDT_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int SAMPLES_DEF = 10;
	localparam int TRIM_SHIFT_DEF = 3;
	// Start-up configuration byte; the enable bit starts the watchdog
	localparam logic [7:0] WDT_OPTION = 8'hef;
	localparam int WDT_EN_BIT = 5;
	localparam logic [DATA_W-1:0] WDT_KICK_KEY = 32'h0000_00ac;
	// Interval (in clock cycles) that corresponds to the 30 W load level
	localparam logic [CAP_W-1:0] THRESH_30W_DEF = 28'h013_12d0;
	localparam logic [ADDR_W-1:0] REG_THRESH = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] REG_RESULT = 4'h2;
	localparam logic [ADDR_W-1:0] REG_LAST = 4'h3;
	localparam logic [ADDR_W-1:0] REG_WDT = 4'h4;
	localparam int ST_TIMEOUT = 0;
	localparam int ST_SLAVE_FLAG = 1;
	localparam int ST_SLAVE = 2;
	localparam int ST_MASTER = 3;
	localparam int ST_WDT = 4;
	localparam int ST_VALID = 5;
	localparam int ST_STATE = 8;
	typedef enum logic [5:0] {
		S_INIT = 6'h01,
		S_IDLE = 6'h02,
		S_CHECK = 6'h04,
		S_MEAS = 6'h08,
		S_SLAVE = 6'h10,
		S_EXC = 6'h20
	} state_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
endpackage

// ---- logic/outlet_linkage_relay_ctrl.sv ----
// Outlet linkage relay controller: pulse interval filter, timeout and relay sequencer
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/100ps
module outlet_linkage_relay_ctrl
	import outlet_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYC_DEF,
	parameter int WDT_CYC = WDT_CYC_DEF,
	parameter int SAMPLES = SAMPLES_DEF,
	parameter int TRIM_SHIFT = TRIM_SHIFT_DEF,
	parameter logic [CAP_W-1:0] THRESH_DEF = THRESH_30W_DEF
)(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic meter_pulse_i,
	input wire bus_req_t bus_i,
	output logic [DATA_W-1:0] rdata_o,
	output logic slave_relay_drive_o,
	output logic master_relay_drive_o
);
	localparam int IDX_W = $clog2(SAMPLES);
	localparam int FILL_W = $clog2(SAMPLES + 1);
	localparam int QCNT_W = $clog2(TICKS_TO_TIMEOUT + 1);
	localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(SAMPLES);
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(SAMPLES - 1);
	localparam logic [QCNT_W-1:0] QCNT_LIMIT = QCNT_W'(TICKS_TO_TIMEOUT);
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);
	localparam logic [31:0] WDT_LAST = 32'(WDT_CYC - 1);
	localparam logic [CAP_W-1:0] CAP_MAX = '1;
	// Enable is fixed at start-up like a configuration byte; software cannot stop the watchdog
	localparam logic WDT_ON = WDT_OPTION[WDT_EN_BIT];

	// Trimming drops one maximum and one minimum, the rest must divide by a shift
	if (SAMPLES - 2 != (1 << TRIM_SHIFT)) begin : g_bad_samples
		$error("SAMPLES must equal two plus a power of two given by TRIM_SHIFT");
	end
	if (TICK_CYC < 2 || WDT_CYC < 2) begin : g_bad_counts
		$error("TICK_CYC and WDT_CYC must be at least two");
	end

	// The sum is only a few bits wider than one sample
	if (SAMPLES > (1 << (SUM_W - CAP_W))) begin : g_bad_sum
		$error("SAMPLES too large for the interval sum width");
	end

	// A quiet period beyond the capture range would let intervals saturate unseen
	if (longint'(TICK_CYC) * TICKS_TO_TIMEOUT > longint'(CAP_MAX)) begin : g_bad_quiet
		$error("Quiet period must fit the interval counter range");
	end

	state_t state;
	logic clear_work;
	logic pulse_meta;
	logic pulse_sync;
	logic pulse_prev;
	logic pulse_rise;
	logic [31:0] tick_cnt;
	logic tick;
	logic [QCNT_W-1:0] quiet_cnt;
	logic sup_timeout;
	logic [CAP_W-1:0] interval_cnt;
	logic armed;
	logic [CAP_W-1:0] samples [SAMPLES];
	logic [IDX_W-1:0] wr_idx;
	logic [FILL_W-1:0] fill;
	logic [CAP_W-1:0] last_interval;
	logic [SUM_W-1:0] sum;
	logic [CAP_W-1:0] smax;
	logic [CAP_W-1:0] smin;
	logic [SUM_W-1:0] trimmed;
	logic [CAP_W-1:0] filt_result;
	logic result_valid;
	logic timeout_flag;
	logic slave_flag;
	logic [CAP_W-1:0] threshold;
	logic [31:0] wdt_cnt;
	logic wdt_expire;
	logic wdt_flag;
	logic wdt_kick;
	logic [DATA_W-1:0] status_word;

	assign clear_work = (state == S_INIT) || (state == S_EXC);
	// A key, not any write, restarts the watchdog, so a stray write cannot hide a hang
	assign wdt_kick = bus_i.wr && (bus_i.addr == REG_WDT) && (bus_i.wdata == WDT_KICK_KEY);

	// The meter pulse is asynchronous; only the second stage is looked at
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pulse_meta <= 1'b0;
			pulse_sync <= 1'b0;
			pulse_prev <= 1'b0;
		end else begin
			pulse_meta <= meter_pulse_i;
			pulse_sync <= pulse_meta;
			pulse_prev <= pulse_sync;
		end
	end
	// Previous stage resets low like the idle line, so no false edge follows reset
	assign pulse_rise = pulse_sync && !pulse_prev;

	// Tick divider from the single system clock
	// Restarted by reinit so the quiet count begins from a whole tick period
	always_ff @(posedge clock_i) begin
		if (rst_i || clear_work) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else if (tick_cnt == TICK_LAST) begin
			tick_cnt <= '0;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			tick <= 1'b0;
		end
	end

	// Ticks without a pulse; a pulse restarts the count
	always_ff @(posedge clock_i) begin
		if (rst_i || clear_work) begin
			quiet_cnt <= '0;
		end else if (pulse_rise) begin
			quiet_cnt <= '0;
		end else if (tick && quiet_cnt != QCNT_LIMIT) begin
			quiet_cnt <= quiet_cnt + QCNT_W'(1);
		end
	end
	assign sup_timeout = (quiet_cnt == QCNT_LIMIT);

	// Interval capture: the first edge only arms, later edges store a sample
	always_ff @(posedge clock_i) begin
		if (rst_i || clear_work) begin
			interval_cnt <= '0;
			armed <= 1'b0;
			wr_idx <= '0;
			fill <= '0;
			last_interval <= '0;
		end else if (pulse_rise) begin
			interval_cnt <= '0;
			armed <= 1'b1;
			if (armed) begin
				last_interval <= interval_cnt;
				wr_idx <= (wr_idx == IDX_LAST) ? '0 : wr_idx + IDX_W'(1);
				if (fill != FILL_FULL) begin
					fill <= fill + FILL_W'(1);
				end
			end
		end else if (sup_timeout) begin
			// Samples older than the quiet period describe a load that is gone
			interval_cnt <= '0;
			armed <= 1'b0;
			fill <= '0;
			// Saturate rather than wrap, so a very slow meter reads as low power
		end else if (interval_cnt != CAP_MAX) begin
			interval_cnt <= interval_cnt + CAP_W'(1);
		end
	end

	// Sample store kept in a plain array, written round robin
	always_ff @(posedge clock_i) begin
		if (pulse_rise && armed && !rst_i && !clear_work) begin
			samples[wr_idx] <= interval_cnt;
		end
	end

	// Trimmed mean over the full window
	// Unwritten slots are never used: the compare waits for a full window
	always_comb begin
		sum = '0;
		smax = '0;
		smin = CAP_MAX;
		for (int i = 0; i < SAMPLES; i++) begin
			sum = sum + SUM_W'(samples[i]);
			if (samples[i] > smax) begin
				smax = samples[i];
			end
			if (samples[i] < smin) begin
				smin = samples[i];
			end
		end
		trimmed = (sum - SUM_W'(smax) - SUM_W'(smin)) >> TRIM_SHIFT;
	end

	// Sequencer; a watchdog expiry is handled like a corrupted state
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= S_INIT;
		end else if (wdt_expire) begin
			state <= S_EXC;
		end else begin
			unique case (state)
				S_INIT: begin
					state <= S_IDLE;
				end
				S_IDLE: begin
					state <= S_CHECK;
				end
				S_CHECK: begin
					// A quiet meter skips the filter, so stale samples never reach the relay
					state <= sup_timeout ? S_SLAVE : S_MEAS;
				end
				S_MEAS: begin
					state <= S_SLAVE;
				end
				S_SLAVE: begin
					state <= S_IDLE;
				end
				S_EXC: begin
					state <= S_IDLE;
				end
				default: begin
					// Any code outside the one-hot set is treated as corruption
					state <= S_EXC;
				end
			endcase
		end
	end

	// Timeout flag is taken in the check state only
	always_ff @(posedge clock_i) begin
		if (rst_i || clear_work) begin
			timeout_flag <= 1'b0;
		end else if (state == S_CHECK) begin
			timeout_flag <= sup_timeout;
		end
	end

	// Short intervals mean high power: above threshold when interval is below
	always_ff @(posedge clock_i) begin
		if (rst_i || clear_work) begin
			slave_flag <= 1'b0;
			filt_result <= '0;
			result_valid <= 1'b0;
		end else if (sup_timeout) begin
			// Samples are being discarded, so the last verdict must not outlive them
			slave_flag <= 1'b0;
		end else if (state == S_MEAS && fill == FILL_FULL) begin
			filt_result <= trimmed[CAP_W-1:0];
			result_valid <= 1'b1;
			slave_flag <= (trimmed[CAP_W-1:0] < threshold);
		end
	end

	// Relay drives; the slave relay is set only in the slave-control state and cleared in the init and exception states
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			slave_relay_drive_o <= 1'b0;
			master_relay_drive_o <= 1'b0;
		end else begin
			if (clear_work) begin
				slave_relay_drive_o <= 1'b0;
				// Master outlet stays powered from here on; only reset takes it down
				master_relay_drive_o <= 1'b1;
			end else if (state == S_SLAVE) begin
				slave_relay_drive_o <= slave_flag && !timeout_flag;
			end
		end
	end

	// Watchdog runs from reset release whenever the configuration enables it
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wdt_cnt <= '0;
			wdt_expire <= 1'b0;
		end else if (!WDT_ON || wdt_kick) begin
			wdt_cnt <= '0;
			wdt_expire <= 1'b0;
		end else if (wdt_cnt == WDT_LAST) begin
			wdt_cnt <= '0;
			wdt_expire <= 1'b1;
		end else begin
			wdt_cnt <= wdt_cnt + 32'h0000_0001;
			wdt_expire <= 1'b0;
		end
	end

	// Sticky expiry flag; a new expiry beats a kick in the same cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wdt_flag <= 1'b0;
		end else if (wdt_expire) begin
			wdt_flag <= 1'b1;
		end else if (wdt_kick) begin
			wdt_flag <= 1'b0;
		end
	end

	// Threshold register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			threshold <= THRESH_DEF;
		end else if (bus_i.wr && bus_i.addr == REG_THRESH) begin
			threshold <= bus_i.wdata[CAP_W-1:0];
		end
	end

	// Snapshot of flags and state; reading clears nothing
	always_comb begin
		status_word = '0;
		status_word[ST_TIMEOUT] = timeout_flag;
		status_word[ST_SLAVE_FLAG] = slave_flag;
		status_word[ST_SLAVE] = slave_relay_drive_o;
		status_word[ST_MASTER] = master_relay_drive_o;
		status_word[ST_WDT] = wdt_flag;
		status_word[ST_VALID] = result_valid;
		status_word[ST_STATE +: 6] = state;
	end

	// Read data stands only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clock_i) begin
		if (rst_i || !bus_i.rd) begin
			rdata_o <= '0;
		end else begin
			unique case (bus_i.addr)
				REG_THRESH: rdata_o <= DATA_W'(threshold);
				REG_STATUS: rdata_o <= status_word;
				REG_RESULT: rdata_o <= DATA_W'(filt_result);
				REG_LAST: rdata_o <= DATA_W'(last_interval);
				default: rdata_o <= '0;
			endcase
		end
	end
endmodule

// ---- bench/outlet_props.sv ----
// Port checker for the outlet linkage relay controller
`timescale 1ns/100ps
module outlet_props
	import outlet_pkg::*;
#(
	parameter int TICK_CYC = 20,
	parameter int WDT_CYC = 200,
	parameter logic [CAP_W-1:0] THRESH_DEF = THRESH_30W_DEF
)(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic meter_pulse_i,
	input wire bus_req_t bus_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic slave_relay_drive_o,
	input wire logic master_relay_drive_o
);
	logic [CAP_W-1:0] thr;
	logic [31:0] quiet;
	logic [31:0] wcnt;
	logic last_pulse;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Shadow of the threshold and of the quiet and watchdog times
	always_ff @(posedge clock_i) begin
		last_pulse <= meter_pulse_i;
		if (rst_i) begin
			thr <= THRESH_DEF;
			quiet <= 32'h0;
			wcnt <= 32'h0;
		end else begin
			if (bus_i.wr && bus_i.addr == REG_THRESH) thr <= bus_i.wdata[CAP_W-1:0];
			quiet <= (meter_pulse_i && !last_pulse) ? 32'h0 : quiet + 32'(quiet != '1);
			wcnt <= (bus_i.wr && bus_i.addr == REG_WDT && bus_i.wdata == WDT_KICK_KEY) ? 32'h0 : wcnt + 32'h1;
		end
	end
	// Reset itself is the cause here, so this one is not disabled by it
	property p_reset_off; disable iff (1'b0) rst_i |=> !slave_relay_drive_o && !master_relay_drive_o; endproperty
	a_reset_off: assert property (p_reset_off) else $error("relay on during reset");
	property p_master_on; $fell(rst_i) |=> master_relay_drive_o; endproperty
	a_master_on: assert property (p_master_on) else $error("master relay late after init");
	property p_master_hold; master_relay_drive_o |=> master_relay_drive_o; endproperty
	a_master_hold: assert property (p_master_hold) else $error("master relay dropped");
	property p_slave_settle; $changed(slave_relay_drive_o) |=> $stable(slave_relay_drive_o)[*2]; endproperty
	a_slave_settle: assert property (p_slave_settle) else $error("slave relay changed outside loop");
	property p_quiet_off; quiet >= 12 * TICK_CYC |-> !slave_relay_drive_o; endproperty
	a_quiet_off: assert property (p_quiet_off) else $error("slave on without meter pulses");
	property p_thresh_read; bus_i.rd && bus_i.addr == REG_THRESH |=> rdata_o == DATA_W'(thr); endproperty
	a_thresh_read: assert property (p_thresh_read) else $error("threshold readback wrong");
	property p_wdt_fire; bus_i.rd && bus_i.addr == REG_STATUS && wcnt > WDT_CYC + 4 |=> rdata_o[ST_WDT]; endproperty
	a_wdt_fire: assert property (p_wdt_fire) else $error("watchdog did not expire");
	property p_state_legal; bus_i.rd && bus_i.addr == REG_STATUS |=> $onehot(rdata_o[ST_STATE+:6]); endproperty
	a_state_legal: assert property (p_state_legal) else $error("state code not legal");
endmodule
bind outlet_linkage_relay_ctrl outlet_props #(.TICK_CYC(TICK_CYC), .WDT_CYC(WDT_CYC), .THRESH_DEF(THRESH_DEF)) props_u (
	.clock_i(clock_i), .rst_i(rst_i), .meter_pulse_i(meter_pulse_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.slave_relay_drive_o(slave_relay_drive_o), .master_relay_drive_o(master_relay_drive_o));

// ---- bench/meter_model.sv ----
// Behavioural metering chip: square wave whose rate follows the load
`timescale 1ns/100ps
module meter_model (
	input wire logic clock_i,
	input wire logic [15:0] period_i,
	output logic pulse_o
);
	logic [15:0] cnt = 16'h0;
	initial pulse_o = 1'b0;
	// Shorter period means more power; no load parks the line low
	always @(posedge clock_i) begin
		cnt <= (period_i == 16'h0 || cnt >= period_i - 16'h1) ? 16'h0 : cnt + 16'h1;
		pulse_o <= period_i != 16'h0 && cnt < (period_i >> 1);
	end
endmodule

// ---- bench/tb_outlet_linkage_relay_ctrl.sv ----
// Self-checking bench for the outlet linkage relay controller
`timescale 1ns/100ps
module tb_outlet_linkage_relay_ctrl;
	import outlet_pkg::*;
	localparam int WDT = 20000;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	bus_req_t bus_i = '0;
	logic [DATA_W-1:0] rdata_o;
	logic slave_o;
	logic master_o;
	logic pulse;
	logic [15:0] period = 16'h0;
	logic [63:0] expq[$];
	logic [63:0] note;
	logic pend = 1'b0;
	logic [27:0] thr;
	int fails = 0;
	int checks_done = 0;
	int t;
	outlet_linkage_relay_ctrl #(.TICK_CYC(20), .WDT_CYC(WDT)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
		.meter_pulse_i(pulse), .bus_i(bus_i), .rdata_o(rdata_o), .slave_relay_drive_o(slave_o),
		.master_relay_drive_o(master_o));
	meter_model meter_u (.clock_i(clock_i), .period_i(period), .pulse_o(pulse));
	initial begin
		forever #4 clock_i = ~clock_i;
	end
	task automatic end_sim;
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		checks_done++;
		if ((got & m) !== (exp & m)) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got & m, exp & m);
		end
	endtask
	// k: 0 idle, 1 write, 2 read; for a read d is the expected word
	task automatic acc(input int k, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
		bus_i <= '{addr: a, wdata: d, wr: k == 1, rd: k == 2};
		if (k == 2) expq.push_back({d, m});
		@(posedge clock_i);
	endtask
	task automatic wait_slave(input logic e, input int lim);
		t = 0;
		while (slave_o !== e && t < lim) begin
			@(posedge clock_i);
			t++;
		end
		cmp({31'h0, slave_o}, {31'h0, e}, 32'h1);
		if (slave_o !== e) end_sim();
	endtask
	always @(posedge clock_i) begin
		if (pend) begin
			note = expq.pop_front();
			cmp(rdata_o, note[63:32], note[31:0]);
		end
		pend <= bus_i.rd;
	end
	initial begin
		void'($urandom(32'hfcb1));
		thr = 28'd60 + 28'($urandom % 100);
		repeat (10) @(posedge clock_i);
		cmp({30'h0, slave_o, master_o}, 32'h0, 32'h3);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		cmp({31'h0, master_o}, 32'h1, 32'h1);
		acc(2, REG_THRESH, 32'(THRESH_30W_DEF), '1);
		acc(1, REG_THRESH, 32'(thr), 0);
		acc(2, REG_THRESH, 32'(thr), '1);
		acc(2, 4'hf, 32'h0, '1);
		// Periods thr and thr+1 straddle the strict threshold compare
		for (int i = 0; i < 3; i++) begin
			acc(1, REG_WDT, WDT_KICK_KEY, 0);
			acc(0, 4'h0, 32'h0, 0);
			period <= 16'(thr) + 16'(i == 1);
			wait_slave(i != 1, 16 * (thr + 1));
			acc(2, REG_STATUS, (i != 1) ? 32'h2e : 32'h28, 32'h2f);
			acc(2, REG_RESULT, 32'(thr) - 32'(i != 1), '1);
			acc(2, REG_LAST, 32'(thr) - 32'(i != 1), '1);
			acc(0, 4'h0, 32'h0, 0);
		end
		period <= 16'h0;
		wait_slave(1'b0, 300);
		acc(2, REG_STATUS, 32'h9, 32'h0f);
		acc(0, 4'h0, 32'h0, 0);
		period <= 16'(thr);
		wait_slave(1'b1, 16 * thr);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		cmp({30'h0, slave_o, master_o}, 32'h0, 32'h3);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		cmp({31'h0, master_o}, 32'h1, 32'h1);
		period <= 16'h0;
		repeat (WDT + 50) @(posedge clock_i);
		acc(2, REG_STATUS, 32'h18, 32'h18);
		acc(1, REG_WDT, WDT_KICK_KEY, 0);
		acc(2, REG_STATUS, 32'h0, 32'h10);
		acc(0, 4'h0, 32'h0, 0);
		repeat (3) @(posedge clock_i);
		end_sim();
	end
endmodule
